// *** pkg/vpgc_consts.vh ***
// vpgc_consts.vh: register offsets, field layout, reset values and scaling constants for the voice path gain block
// assumes: included by bare name from the design files, no other header depends on it
`ifndef VPGC_CONSTS_VH
`define VPGC_CONSTS_VH

// register offsets on the 8-bit register port
`define VPGC_TX_GAIN_STAGE2_ADDR 8'h26
`define VPGC_RX_GAIN_STAGE2_ADDR 8'h27
`define VPGC_TX_GAIN_STAGE3_ADDR 8'h28

// field layout inside each gain register
`define VPGC_DIR_BIT 4
`define VPGC_STEP_MSB 3
`define VPGC_STEP_LSB 0
`define VPGC_FIELD_W 5

// reset values
`define VPGC_TX_GAIN_STAGE2_RST 5'h00
`define VPGC_RX_GAIN_STAGE2_RST 5'h00
`define VPGC_TX_GAIN_STAGE3_RST 5'h00
`define VPGC_RDATA_RST 8'h00

// scale factors are unsigned with this many fraction bits
`define VPGC_FRAC_BITS 12
`define VPGC_UNITY_COEF 16'h1000
`define VPGC_GAIN_MAX_STEP 4'hC

`endif

// *** verilog/vpgc_scale_stage.v ***
// vpgc_scale_stage.v: one gain or attenuation stage, 1 dB steps, applied to a signed sample stream
// assumes: samples arrive with a one-cycle valid strobe on core_clk; direction and steps may change any time
`timescale 1ns/1ns
`default_nettype none
`include "vpgc_consts.vh"

module vpgc_scale_stage #(
  parameter SAMPLE_W = 16
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  input wire signed [SAMPLE_W-1:0] in_data,
  input wire direction,
  input wire [3:0] steps,
  output reg out_valid,
  output reg signed [SAMPLE_W-1:0] out_data
);

  // gain table in 1 dB steps, index 0 is unity
  function [15:0] gain_coef;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: gain_coef = 16'h1000;
        4'h1: gain_coef = 16'h11F4;
        4'h2: gain_coef = 16'h1425;
        4'h3: gain_coef = 16'h169A;
        4'h4: gain_coef = 16'h195C;
        4'h5: gain_coef = 16'h1C74;
        4'h6: gain_coef = 16'h1FED;
        4'h7: gain_coef = 16'h23D2;
        4'h8: gain_coef = 16'h2831;
        4'h9: gain_coef = 16'h2D18;
        4'hA: gain_coef = 16'h3299;
        4'hB: gain_coef = 16'h38C5;
        default: gain_coef = 16'h3FB2;
      endcase
    end
  endfunction

  // attenuation table in 1 dB steps, index 0 is unity
  function [15:0] atten_coef;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: atten_coef = 16'h1000;
        4'h1: atten_coef = 16'h0E43;
        4'h2: atten_coef = 16'h0CB6;
        4'h3: atten_coef = 16'h0B54;
        4'h4: atten_coef = 16'h0A18;
        4'h5: atten_coef = 16'h08FF;
        4'h6: atten_coef = 16'h0805;
        4'h7: atten_coef = 16'h0726;
        4'h8: atten_coef = 16'h065F;
        4'h9: atten_coef = 16'h05AD;
        4'hA: atten_coef = 16'h050F;
        4'hB: atten_coef = 16'h0482;
        4'hC: atten_coef = 16'h0405;
        4'hD: atten_coef = 16'h0395;
        4'hE: atten_coef = 16'h0331;
        default: atten_coef = 16'h02D8;
      endcase
    end
  endfunction

  reg [15:0] coef;
  wire signed [16:0] coef_s;
  wire signed [SAMPLE_W+16:0] product;
  wire signed [SAMPLE_W+16:0] shifted;
  wire over_pos;
  wire over_neg;

  // decoded from the live register value, so a new setting hits the very next sample
  always @*
  begin
    if (steps == 4'h0)
      coef = `VPGC_UNITY_COEF;
    else if (!direction)
      coef = gain_coef((steps >= `VPGC_GAIN_MAX_STEP) ? `VPGC_GAIN_MAX_STEP : steps);
    else
      coef = atten_coef(steps);
  end

  assign coef_s = {1'b0, coef};
  assign product = in_data * coef_s;
  assign shifted = product >>> `VPGC_FRAC_BITS;
  // 12 dB of gain on a loud sample would wrap, so clip at full scale instead
  assign over_pos = (shifted > $signed({{17{1'b0}}, 1'b0, {(SAMPLE_W-1){1'b1}}}));
  assign over_neg = (shifted < $signed({{17{1'b1}}, 1'b1, {(SAMPLE_W-1){1'b0}}}));

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= {SAMPLE_W{1'b0}};
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        if (over_pos)
          out_data <= {1'b0, {(SAMPLE_W-1){1'b1}}};
        else if (over_neg)
          out_data <= {1'b1, {(SAMPLE_W-1){1'b0}}};
        else
          out_data <= shifted[SAMPLE_W-1:0];
      end
    end
  end

endmodule // vpgc_scale_stage

`default_nettype wire

// *** verilog/vpgc_gain_control.v ***
// vpgc_gain_control.v: gain registers and scaling of the transmit and receive sample streams
// assumes: single-cycle register strobes on core_clk, samples in 2s complement with a valid strobe
//
// Behaviour
// - tx stage 2, direction 0: steps raise gain
// - tx stage 2, direction 1: steps raise attenuation
// - one step is 1 dB, 12 up, 15 down
// - tx stage 2 steps zero gives 0 dB
// - tx stage 2 gain 11xx saturates at 12 dB
// - tx stage 2 attenuation 1111 15 dB, 0001 1 dB
// - rx stage 2, direction 0: steps raise gain
// - rx stage 2, direction 1: steps raise attenuation
// - rx stage 2 steps zero gives 0 dB
// - rx stage 2 gain step one gives 1 dB
// - rx stage 2 gain 11xx saturates at 12 dB
// - rx stage 2 attenuation step one 1 dB
// - rx stage 2 attenuation 1111 gives 15 dB
// - tx stage 3 direction chooses gain or attenuation
// - tx stage 3 steps zero gives 0 dB
// - tx stage 2 register resets to zero
`timescale 1ns/1ns
`default_nettype none
`include "vpgc_consts.vh"

module vpgc_gain_control #(
  parameter SAMPLE_W = 16
) (
  input wire core_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire tx_in_valid,
  input wire signed [SAMPLE_W-1:0] tx_in_data,
  output wire tx_out_valid,
  output wire signed [SAMPLE_W-1:0] tx_out_data,
  input wire rx_in_valid,
  input wire signed [SAMPLE_W-1:0] rx_in_data,
  output wire rx_out_valid,
  output wire signed [SAMPLE_W-1:0] rx_out_data
);

  // only the five defined bits are stored; reserved bits have no flops at all
  reg [`VPGC_FIELD_W-1:0] tx_gain_stage2;
  reg [`VPGC_FIELD_W-1:0] rx_gain_stage2;
  reg [`VPGC_FIELD_W-1:0] tx_gain_stage3;
  reg [7:0] next_rdata;
  wire tx_mid_valid;
  wire signed [SAMPLE_W-1:0] tx_mid_data;

  wire tx_stage2_direction;
  wire [3:0] tx_stage2_steps;
  wire rx_stage2_direction;
  wire [3:0] rx_stage2_steps;
  wire tx_stage3_direction;
  wire [3:0] tx_stage3_steps;

  assign tx_stage2_direction = tx_gain_stage2[`VPGC_DIR_BIT];
  assign tx_stage2_steps = tx_gain_stage2[`VPGC_STEP_MSB:`VPGC_STEP_LSB];
  assign rx_stage2_direction = rx_gain_stage2[`VPGC_DIR_BIT];
  assign rx_stage2_steps = rx_gain_stage2[`VPGC_STEP_MSB:`VPGC_STEP_LSB];
  assign tx_stage3_direction = tx_gain_stage3[`VPGC_DIR_BIT];
  assign tx_stage3_steps = tx_gain_stage3[`VPGC_STEP_MSB:`VPGC_STEP_LSB];

  // register writes
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_gain_stage2 <= `VPGC_TX_GAIN_STAGE2_RST;
      rx_gain_stage2 <= `VPGC_RX_GAIN_STAGE2_RST;
      tx_gain_stage3 <= `VPGC_TX_GAIN_STAGE3_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `VPGC_TX_GAIN_STAGE2_ADDR: tx_gain_stage2 <= reg_wdata[`VPGC_FIELD_W-1:0];
        `VPGC_RX_GAIN_STAGE2_ADDR: rx_gain_stage2 <= reg_wdata[`VPGC_FIELD_W-1:0];
        `VPGC_TX_GAIN_STAGE3_ADDR: tx_gain_stage3 <= reg_wdata[`VPGC_FIELD_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always @*
  begin
    case (reg_addr)
      `VPGC_TX_GAIN_STAGE2_ADDR: next_rdata = {3'h0, tx_gain_stage2};
      `VPGC_RX_GAIN_STAGE2_ADDR: next_rdata = {3'h0, rx_gain_stage2};
      `VPGC_TX_GAIN_STAGE3_ADDR: next_rdata = {3'h0, tx_gain_stage3};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= `VPGC_RDATA_RST;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // transmit path: stage 2 then stage 3, one cycle each
  vpgc_scale_stage #(
    .SAMPLE_W(SAMPLE_W)
  ) u_tx_stage2 (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(tx_in_valid),
    .in_data(tx_in_data),
    .direction(tx_stage2_direction),
    .steps(tx_stage2_steps),
    .out_valid(tx_mid_valid),
    .out_data(tx_mid_data)
  );

  vpgc_scale_stage #(
    .SAMPLE_W(SAMPLE_W)
  ) u_tx_stage3 (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(tx_mid_valid),
    .in_data(tx_mid_data),
    .direction(tx_stage3_direction),
    .steps(tx_stage3_steps),
    .out_valid(tx_out_valid),
    .out_data(tx_out_data)
  );

  // receive path: stage 2 only, later stages live elsewhere
  vpgc_scale_stage #(
    .SAMPLE_W(SAMPLE_W)
  ) u_rx_stage2 (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(rx_in_valid),
    .in_data(rx_in_data),
    .direction(rx_stage2_direction),
    .steps(rx_stage2_steps),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data)
  );

endmodule // vpgc_gain_control

`default_nettype wire

// *** verification/vpgc_gain_control_properties.sv ***
// vpgc_gain_control_properties.sv: port-level checks for the voice path gain block
// assumes: bound to vpgc_gain_control from tb, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module vpgc_checker #(
  parameter SAMPLE_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_in_valid,
  input wire logic tx_out_valid,
  input wire logic signed [SAMPLE_W-1:0] tx_out_data,
  input wire logic rx_in_valid,
  input wire logic rx_out_valid,
  input wire logic signed [SAMPLE_W-1:0] rx_out_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rx_latency_a: assert property (rx_in_valid |=> rx_out_valid) else $error("rx strobe late");
  rx_no_spur_a: assert property (rx_out_valid |-> $past(rx_in_valid)) else $error("rx strobe spurious");
  tx_latency_a: assert property (tx_in_valid |-> ##2 tx_out_valid) else $error("tx strobe late");
  tx_no_spur_a: assert property (tx_out_valid |-> $past(tx_in_valid, 2)) else $error("tx strobe spurious");
  // held samples only: a reset clears the data once
  rx_data_hold_a: assert property (!rx_out_valid && !$past(rst) |-> $stable(rx_out_data)) else $error("rx data moved");
  tx_data_hold_a: assert property (!tx_out_valid && !$past(rst) |-> $stable(tx_out_data)) else $error("tx data moved");
  reserved_zero_a: assert property (reg_rdata[7:5] == 3'h0) else $error("reserved bits set");
  unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h26 || reg_addr > 8'h28) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00) else $error("read data not reset");
endmodule // vpgc_checker
`default_nettype wire

// *** verification/tb.sv ***
// tb.sv: directed tests of the gain block through its register and sample ports
// assumes: vpgc_gain_control and vpgc_checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic tx_in_valid = 1'b0;
  logic signed [15:0] tx_in_data = 16'sh1000;
  logic tx_out_valid;
  logic signed [15:0] tx_out_data;
  logic rx_in_valid = 1'b0;
  logic signed [15:0] rx_in_data = 16'sh1000;
  logic rx_out_valid;
  logic signed [15:0] rx_out_data;
  int n_mismatch = 0;
  int n_checks = 0;
  always #5 core_clk = ~core_clk;
  vpgc_gain_control #(.SAMPLE_W(16)) vpgc_gain_control_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask
  // a 0x1000 sample is unity, so the output equals the stage coefficient
  task automatic try(input bit tx, input logic [7:0] a, input logic [7:0] d, input logic [15:0] e);
    wr(a, d);
    @(posedge core_clk);
    tx_in_valid <= tx;
    rx_in_valid <= !tx;
    @(posedge core_clk);
    tx_in_valid <= 1'b0;
    rx_in_valid <= 1'b0;
    if (tx)
      @(posedge core_clk);
    #1 chk("out_valid", {15'h0000, tx ? tx_out_valid : rx_out_valid}, 16'h0001);
    chk("out_data", tx ? tx_out_data : rx_out_data, e);
  endtask
  task automatic t_regs;
    rd(8'h26, 8'h00);
    wr(8'h26, 8'hFF);
    rd(8'h26, 8'h1F);
    wr(8'h28, 8'hF5);
    rd(8'h28, 8'h15);
    rd(8'h30, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_rx;
    try(0, 8'h27, 8'h00, 16'h1000);
    try(0, 8'h27, 8'h10, 16'h1000);
    try(0, 8'h27, 8'h01, 16'h11F4);
    try(0, 8'h27, 8'h06, 16'h1FED);
    try(0, 8'h27, 8'h0C, 16'h3FB2);
    try(0, 8'h27, 8'h0F, 16'h3FB2);
    try(0, 8'h27, 8'h11, 16'h0E43);
    try(0, 8'h27, 8'h13, 16'h0B54);
    try(0, 8'h27, 8'h1F, 16'h02D8);
    $display("test rx done");
  endtask
  task automatic t_tx;
    wr(8'h28, 8'h00);
    try(1, 8'h26, 8'h10, 16'h1000);
    try(1, 8'h26, 8'h01, 16'h11F4);
    try(1, 8'h26, 8'h0D, 16'h3FB2);
    try(1, 8'h26, 8'h11, 16'h0E43);
    try(1, 8'h26, 8'h15, 16'h08FF);
    try(1, 8'h26, 8'h1F, 16'h02D8);
    wr(8'h26, 8'h00);
    try(1, 8'h28, 8'h0C, 16'h3FB2);
    try(1, 8'h28, 8'h1F, 16'h02D8);
    try(1, 8'h28, 8'h10, 16'h1000);
    // both stages at full gain overflow, output clips
    wr(8'h28, 8'h0C);
    try(1, 8'h26, 8'h0C, 16'h7FFF);
    // a negative 0xF000 sample through both stages must clip low, not wrap
    @(posedge core_clk);
    tx_in_data <= 16'shF000;
    try(1, 8'h26, 8'h0C, 16'h8000);
    $display("test tx done");
  endtask
  // a write at the edge that takes a sample leaves that sample on the old setting
  task automatic t_update;
    wr(8'h27, 8'h06);
    @(posedge core_clk);
    rx_in_data <= -16'sh03E8;
    rx_in_valid <= 1'b1;
    reg_addr <= 8'h27;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    rx_in_data <= 16'sh03E8;
    #1 chk("rx_out_data", rx_out_data, 16'hF834);
    @(posedge core_clk);
    rx_in_valid <= 1'b0;
    #1 chk("rx_out_data", rx_out_data, 16'h03E8);
    $display("test update done");
  endtask
  // reset in mid-run must bring registers and outputs back to zero
  task automatic t_reset;
    wr(8'h26, 8'h1F);
    rd(8'h26, 8'h1F);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, 16'h0000);
    chk("tx_out_data", tx_out_data, 16'h0000);
    rd(8'h26, 8'h00);
    $display("test reset done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_update();
    t_tx();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
bind vpgc_gain_control vpgc_checker #(.SAMPLE_W(SAMPLE_W)) vpgc_checker_inst (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid),
  .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .rx_in_valid(rx_in_valid),
  .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data));
`default_nettype wire
